// ===== core/floppy_drive_option_regs.sv
// floppy option register bank: write-protect merge, density override, drive types
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "floppy_opt_map.svh"
// Summary of operation
// - write protect from force, drive pin, global bit
// - forced protect also covers parallel-port drive interface
// - density codes 00/01 pass controller density through
// - code 10 forces one, 11 forces zero
// - drive type register, A low, B next
// - type register resets FF, upper pairs spare storage
// - drive zero is always the boot drive
// - option register resets to 00
// - only hard reset clears; soft reset ignored
module floppy_drive_option_regs (
   // clock and hard reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // soft reset from the host, deliberately without effect here
   input wire logic softReset,
   // AXI4-Lite write address / data / response
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address / data
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // drive pins: native interface and parallel-port routed interface
   input wire floppy_opt_pkg::drive_pins_t nativePins,
   input wire floppy_opt_pkg::drive_pins_t parPortPins,
   input wire logic parPortFdcSel,
   // controller core side
   input wire logic floppyProtectGlobal,
   input wire logic densityCore,
   output logic writeProtectToCore,
   output logic statusRegAWp,
   output logic densitySelectOut,
   output logic [1:0] bootDriveSel
);
   import floppy_opt_pkg::*;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [5:0] pinRaw; // both pin sets, packed for the loop
   logic [5:0] sync1_ff; // first stage, read only by the second
   logic [5:0] sync2_ff; // safe to use
   assign pinRaw = {nativePins, parPortPins};
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_sync
         // two flops per pin; pins arrive from outside the clock domain
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               sync1_ff[gi] <= 1'b1;
               sync2_ff[gi] <= 1'b1;
            end else begin
               sync1_ff[gi] <= pinRaw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate
   drive_pins_t nativeSync; // synchronised native pins
   drive_pins_t parSync; // synchronised parallel-port pins
   drive_pins_t activePins; // set currently routed to the core
   assign nativeSync = sync2_ff[5:3];
   assign parSync = sync2_ff[2:0];
   // the force setting is applied after the mux, so both routes see it
   assign activePins = parPortFdcSel ? parSync : nativeSync;

   // ************************************************************
   // registers and AXI4-Lite slave state
   // ************************************************************
   option_reg_t opt_ff, nxt_opt; // forced protect and density select
   logic [7:0] type_ff, nxt_type; // drive types A and B, upper pairs spare
   logic awHeld_ff, nxt_awHeld; // write address taken, waiting for data
   logic [11:0] awAddr_ff, nxt_awAddr;
   logic wHeld_ff, nxt_wHeld; // write data taken, waiting for address
   logic [7:0] wByte_ff, nxt_wByte; // only the low lane is stored
   logic wLane_ff, nxt_wLane; // low byte strobe of the held data
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   logic wp_ff, nxt_wp; // merged write protect
   logic dens_ff, nxt_dens; // density select to the drive
   logic wrDo; // write performed in this cycle
   logic wpCalc; // combinational merge, before the output flop

   // a new write is accepted only when no response is pending
   assign s_axi_awready = !awHeld_ff && !bvalid_ff;
   assign s_axi_wready = !wHeld_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign wrDo = awHeld_ff && wHeld_ff && !bvalid_ff;
   // force only counts while a drive is selected; pin and global bit always count
   assign wpCalc = (!activePins.dsZeroN && opt_ff.forceWp) || (!activePins.dsOneN && opt_ff.forceWp)
                   || !activePins.protectN || floppyProtectGlobal;

   // next-state logic of the bus slave and the register file
   always_comb begin
      nxt_opt = opt_ff;
      nxt_type = type_ff;
      nxt_awHeld = awHeld_ff;
      nxt_awAddr = awAddr_ff;
      nxt_wHeld = wHeld_ff;
      nxt_wByte = wByte_ff;
      nxt_wLane = wLane_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      // soft reset is not looked at: contents survive it
      // address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_awHeld = 1'b1;
         nxt_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_wHeld = 1'b1;
         nxt_wByte = s_axi_wdata[7:0];
         nxt_wLane = s_axi_wstrb[0];
      end
      // perform the write once both halves are held
      if (wrDo) begin
         nxt_awHeld = 1'b0;
         nxt_wHeld = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = `RESP_OKAY;
         case (awAddr_ff)
            `OPT_ADDR: begin
               // reserved bits are not stored
               if (wLane_ff) begin
                  nxt_opt = {4'h0, wByte_ff[3:2], 1'b0, wByte_ff[0]};
               end
            end
            `TYPE_ADDR: begin
               // all eight bits are storage, the upper pairs as spares
               if (wLane_ff) begin
                  nxt_type = wByte_ff;
               end
            end
            `STAT_ADDR: begin
               // read-only status, write ignored
               nxt_bresp = `RESP_OKAY;
            end
            default: begin
               nxt_bresp = `RESP_SLVERR;
            end
         endcase
      end else if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      // read answers one cycle after the address is taken
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = `RESP_OKAY;
         case (s_axi_araddr)
            `OPT_ADDR: begin
               nxt_rdata = {24'h000000, opt_ff};
            end
            `TYPE_ADDR: begin
               nxt_rdata = {24'h000000, type_ff};
            end
            `STAT_ADDR: begin
               // live state: merged protect and the density actually driven
               nxt_rdata = {30'h0, wp_ff, dens_ff};
            end
            default: begin
               nxt_rdata = 32'h00000000;
               nxt_rresp = `RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
   end
   // next values of the drive-facing outputs
   always_comb begin
      nxt_wp = wpCalc;
      case (opt_ff.densSel)
         `DENS_FORCE_ONE: begin
            nxt_dens = 1'b1;
         end
         `DENS_FORCE_ZERO: begin
            nxt_dens = 1'b0;
         end
         default: begin
            // 00 and 01 both leave the controller in charge
            nxt_dens = densityCore;
         end
      endcase
   end
   // state registers; rst_n is the hard reset, the only one that clears them
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         opt_ff <= `OPT_RESET;
         type_ff <= `TYPE_RESET;
         awHeld_ff <= 1'b0;
         awAddr_ff <= 12'h000;
         wHeld_ff <= 1'b0;
         wByte_ff <= 8'h00;
         wLane_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= `RESP_OKAY;
         wp_ff <= 1'b0;
         dens_ff <= 1'b0;
      end else begin
         opt_ff <= nxt_opt;
         type_ff <= nxt_type;
         awHeld_ff <= nxt_awHeld;
         awAddr_ff <= nxt_awAddr;
         wHeld_ff <= nxt_wHeld;
         wByte_ff <= nxt_wByte;
         wLane_ff <= nxt_wLane;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
         wp_ff <= nxt_wp;
         dens_ff <= nxt_dens;
      end
   end
   // ************************************************************
   // outputs
   // ************************************************************
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign writeProtectToCore = wp_ff;
   assign statusRegAWp = wp_ff;
   assign densitySelectOut = dens_ff;
   // drive types never change which drive boots
   assign bootDriveSel = `BOOT_DRIVE;
   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // the release edge still clears the flops, so attempts start only once rst_n was sampled high
   property p_wpMerge;
      rst_n |=> (writeProtectToCore == $past(wpCalc)) && (statusRegAWp == writeProtectToCore);
   endproperty
   a_wpMerge: assert property (p_wpMerge) else $error("write protect merge wrong");
   property p_parForce;
      (parPortFdcSel && opt_ff.forceWp && !parSync.dsZeroN) |=> writeProtectToCore;
   endproperty
   a_parForce: assert property (p_parForce) else $error("force ignored on parallel port");
   property p_densPass;
      rst_n && (opt_ff.densSel[1] == 1'b0) |=> (densitySelectOut == $past(densityCore));
   endproperty
   a_densPass: assert property (p_densPass) else $error("density not passed through");
   property p_densOne;
      (opt_ff.densSel == `DENS_FORCE_ONE) |=> densitySelectOut;
   endproperty
   a_densOne: assert property (p_densOne) else $error("density not forced to one");
   property p_densZero;
      (opt_ff.densSel == `DENS_FORCE_ZERO) |=> !densitySelectOut;
   endproperty
   a_densZero: assert property (p_densZero) else $error("density not forced to zero");
   property p_typeWrite;
      (wrDo && wLane_ff && (awAddr_ff == `TYPE_ADDR)) |=> (type_ff == $past(wByte_ff)) ##1 $stable(type_ff) [*1];
   endproperty
   a_typeWrite: assert property (p_typeWrite) else $error("type register write lost");
   property p_typeReset;
      $rose(rst_n) |-> (type_ff == `TYPE_RESET);
   endproperty
   a_typeReset: assert property (p_typeReset) else $error("type register reset value wrong");
   property p_bootDrive;
      bootDriveSel == `BOOT_DRIVE;
   endproperty
   a_bootDrive: assert property (p_bootDrive) else $error("boot drive is not zero");
   property p_optReset;
      $rose(rst_n) |-> (opt_ff == `OPT_RESET);
   endproperty
   a_optReset: assert property (p_optReset) else $error("option register reset value wrong");
   property p_softKeep;
      (softReset && !wrDo) |=> ($stable(opt_ff) && $stable(type_ff));
   endproperty
   a_softKeep: assert property (p_softKeep) else $error("soft reset changed registers");
endmodule // floppy_drive_option_regs

// ===== pkg/floppy_opt_map.svh
// offsets, reset values, codes and fixed values of the floppy option registers
`ifndef FLOPPY_OPT_MAP_SVH
`define FLOPPY_OPT_MAP_SVH
// ************************************************************
// register indices and byte addresses (byte address = 4 * index)
// ************************************************************
`define OPT_INDEX 8'hF1
`define TYPE_INDEX 8'hF2
`define STAT_INDEX 8'hF8
`define OPT_ADDR {2'b00, `OPT_INDEX, 2'b00}
`define TYPE_ADDR {2'b00, `TYPE_INDEX, 2'b00}
`define STAT_ADDR {2'b00, `STAT_INDEX, 2'b00}
// ************************************************************
// reset values
// ************************************************************
`define OPT_RESET 8'h00
`define TYPE_RESET 8'hFF
// ************************************************************
// density select codes and fixed values
// ************************************************************
`define DENS_FORCE_ONE 2'h2
`define DENS_FORCE_ZERO 2'h3
`define BOOT_DRIVE 2'h0
// ************************************************************
// AXI4-Lite response codes
// ************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== pkg/floppy_opt_pkg.sv
// types shared by the floppy option register bank
package floppy_opt_pkg;
   // one set of drive-side pins, all active low
   typedef struct packed {
      logic dsZeroN; // drive 0 selected when low
      logic dsOneN; // drive 1 selected when low
      logic protectN; // drive reports write protect when low
   } drive_pins_t;
   // write-protect / density option register layout
   typedef struct packed {
      logic [3:0] rsvdHi; // reads as zero
      logic [1:0] densSel; // density select override
      logic rsvd1; // reads as zero
      logic forceWp; // forced write protect
   } option_reg_t;
endpackage

// ===== test/floppy_drive_model.sv
// drive-side partner: holds the pins of the native and the parallel-port drive sets
module floppy_drive_model (
   // clock and hard reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // requested levels: native set in 5:3, parallel-port set in 2:0
   input wire logic [5:0] pinWish,
   // pins seen by the option block
   output floppy_opt_pkg::drive_pins_t nativePins,
   output floppy_opt_pkg::drive_pins_t parPortPins
);
   timeunit 1ns;
   timeprecision 100ps;
   import floppy_opt_pkg::*;
   // ********************
   // pin drivers
   // ********************
   // pins move only after an edge; the cable pull-ups keep every pin inactive during reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         nativePins <= 3'h7;
         parPortPins <= 3'h7;
      end else begin
         nativePins <= pinWish[5:3];
         parPortPins <= pinWish[2:0];
      end
   end
endmodule // floppy_drive_model

// ===== test/floppy_drive_option_regs_bench.sv
// self-checking bench for the floppy option register bank
`include "floppy_opt_map.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module floppy_drive_option_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import floppy_opt_pkg::*;
   // ********************
   // signals
   // ********************
   logic clk_sys, rst_n, softReset;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, bootDriveSel, resp;
   drive_pins_t nativePins, parPortPins, pick;
   logic [5:0] pinWish; // partner command: native 5:3, parallel port 2:0
   logic parPortFdcSel, floppyProtectGlobal, densityCore;
   logic writeProtectToCore, statusRegAWp, densitySelectOut, expW, expD;
   logic [7:0] v; // last value written
   int error_cnt = 0;
   int n_compared = 0;
   int seed = 80911;
   // ********************
   // clock and instances
   // ********************
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   floppy_drive_option_regs DUT (.clk_sys, .rst_n, .softReset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .nativePins, .parPortPins, .parPortFdcSel, .floppyProtectGlobal, .densityCore, .writeProtectToCore,
      .statusRegAWp, .densitySelectOut, .bootDriveSel);
   floppy_drive_model drives (.clk_sys, .rst_n, .pinWish, .nativePins, .parPortPins);
   // ********************
   // bus tasks and verdict
   // ********************
   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // expected merged protect: the force only counts while a drive is selected
   function automatic logic expectWp(input drive_pins_t p, input logic frc, input logic glb);
      return (!p.dsZeroN && frc) || (!p.dsOneN && frc) || !p.protectN || glb;
   endfunction
   // expected density pin: codes 10 and 11 force a level, 00 and 01 pass the controller's
   function automatic logic expectDens(input logic [1:0] code, input logic core);
      return code[1] ? !code[0] : core;
   endfunction
   // address and data offered together, each dropped once taken; upper data bits are noise
   task automatic axiWrite(input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'($random(seed)), d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 40);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (!s_axi_bvalid) begin
         error_cnt++;
         final_report();
      end
   endtask
   task automatic axiRead(input logic [11:0] a);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 40);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (!s_axi_rvalid) begin
         error_cnt++;
         final_report();
      end
   endtask
   // ********************
   // main sequence
   // ********************
   initial begin
      {rst_n, softReset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      s_axi_wstrb = 4'hF;
      pinWish = 6'h3F;
      {parPortFdcSel, floppyProtectGlobal, densityCore} = 3'h0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      axiRead(`TYPE_ADDR);
      `CHK(rd, 32'h000000FF)
      axiRead(`OPT_ADDR);
      `CHK(rd, 32'h00000000)
      `CHK(bootDriveSel, `BOOT_DRIVE)
      $display("reset values done");
      // all-zero corner first, then random drive types including the spare pairs
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'h00 : 8'($random(seed));
         axiWrite(`TYPE_ADDR, v);
         axiRead(`TYPE_ADDR);
         `CHK(rd, {24'h000000, v})
      end
      // soft reset must leave the stored types alone
      @(posedge clk_sys);
      softReset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      softReset <= 1'b0;
      axiRead(`TYPE_ADDR);
      `CHK(rd[7:0], v)
      $display("drive types done");
      // every density code in turn, random pins, pin set and global protect
      for (int i = 0; i < 24; i++) begin
         v = 8'($random(seed));
         v[3:2] = i[1:0];
         @(posedge clk_sys);
         pinWish <= 6'($random(seed)) | ((i % 4 == 3) ? 6'h00 : 6'h09);
         parPortFdcSel <= i[2];
         floppyProtectGlobal <= (i % 7 == 6);
         densityCore <= 1'($random(seed));
         axiWrite(`OPT_ADDR, v);
         repeat (6) @(posedge clk_sys);
         pick = parPortFdcSel ? pinWish[2:0] : pinWish[5:3];
         expW = expectWp(pick, v[0], floppyProtectGlobal);
         expD = expectDens(v[3:2], densityCore);
         `CHK(writeProtectToCore, expW)
         `CHK(statusRegAWp, expW)
         `CHK(densitySelectOut, expD)
         `CHK(bootDriveSel, `BOOT_DRIVE)
         axiRead(`STAT_ADDR);
         `CHK(rd, {30'h0, expW, expD})
         axiRead(`OPT_ADDR);
         `CHK(rd, {24'h000000, v & 8'h0D})
      end
      $display("protect and density done");
      // unmapped addresses answer with an error and no data
      axiRead(12'h000);
      `CHK({resp, rd}, {`RESP_SLVERR, 32'h0})
      axiWrite(12'h004, 8'h5A);
      `CHK(resp, `RESP_SLVERR)
      // hard reset in mid-run restores both defaults
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      axiRead(`TYPE_ADDR);
      `CHK(rd, 32'h000000FF)
      axiRead(`OPT_ADDR);
      `CHK(rd, 32'h00000000)
      // a write without the low byte strobe is answered but stores nothing
      s_axi_wstrb <= 4'hE;
      axiWrite(`TYPE_ADDR, 8'h00);
      `CHK(resp, `RESP_OKAY)
      axiRead(`TYPE_ADDR);
      `CHK(rd, 32'h000000FF)
      $display("errors and hard reset done");
      final_report();
   end
endmodule // floppy_drive_option_regs_bench
